// file: rtl/sar_adc_sampling_sequencer.sv
// scan and trigger sequencer for the successive-approximation converter
`timescale 1ns/1ns
`default_nettype none
`include "sar_seq_regs.svh"
module sar_adc_sampling_sequencer (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // register bus
  input  wire logic [7:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  input  wire logic [3:0]  BYTEENABLE,
  output logic      [31:0] READDATA,
  output logic             WAITREQUEST,
  // motor-control engine
  input  wire logic        FOC_ENABLE,
  input  wire logic [1:0]  FOC_SHUNT_MODE,
  input  wire logic        FOC_TRIGGER,
  output logic             FOC_RESULT_VALID,
  // timer1
  input  wire logic        T1_ENABLE,
  input  wire logic        T1_TRIGGER,
  input  wire logic        TIMER_POSITION_SOURCE_SELECT,
  input  wire logic        PHASE_CHANNEL_SELECT,
  output logic             T1_RESULT_VALID,
  // triggered result
  output logic      [3:0]  TRIG_CHANNEL,
  output logic      [15:0] TRIG_RESULT,
  // converter core
  output logic      [3:0]  CORE_CHANNEL,
  output logic             CORE_SAMPLE,
  output logic             CORE_START,
  input  wire logic        CORE_DONE,
  input  wire logic [11:0] CORE_DATA
);
  typedef struct packed {
    sar_seq_pkg::seq_state_t st;
    sar_seq_pkg::conv_kind_t kind;
    logic [3:0]              ch;
    logic                    en;
    logic                    busy;
    logic                    align;
    logic                    done;
    logic [13:0]             mask;
    logic [13:0]             scan_rem;
    logic [13:0]             foc_pend;
    logic [13:0]             t1_pend;
    logic [7:0]              sper_lo;
    logic [3:0]              sper_hi;
    logic [13:0][15:0]       res; // see RULE_15
    logic                    ack;
    logic [31:0]             rdata;
    logic [7:0]              acc;
    logic                    tick;
    logic                    core_start;
    logic [15:0]             trig_res;
    logic [3:0]              trig_ch;
    logic                    foc_v;
    logic                    t1_v;
  } seq_regs_t;

  seq_regs_t   s;
  seq_regs_t   next_s;
  logic        tmr_start;
  logic        tmr_done;
  logic [5:0]  tmr_len;
  logic [13:0] foc_set;
  logic [13:0] t1_set;
  logic [8:0]  acc_sum;
  logic [31:0] wmerged;

  function automatic logic [3:0] lowest_ch(input logic [13:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [13:0] ch_bit(input logic [3:0] c);
    return 14'h0001 << c;
  endfunction

  // zero fill outside the value in both alignments
  function automatic logic [15:0] align_word(input logic [11:0] v,
                                             input logic        left);
    return left ? {1'b0, v, 3'b000} : {4'h0, v}; // see RULE_16 RULE_17 RULE_18
  endfunction

  function automatic logic [5:0] decode_period(input logic [3:0] f);
    return f[3] ? ({f[2:0], 3'b000} + 6'd7) : {3'b000, f[2:0]}; // see RULE_21
  endfunction

  function automatic logic [5:0] sample_len(input logic [3:0] c,
                                            input logic [7:0] lo,
                                            input logic [3:0] hi);
    if (c <= 4'd4) begin
      return decode_period(lo[3:0]);
    end else if (c <= 4'd7) begin
      return decode_period(lo[7:4]);
    end
    return decode_period(hi);
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  sample_timer u_timer (
    .clk   (CLK),
    .rst_n (RST_N),
    .tick  (s.tick),
    .start (tmr_start),
    .abort (!s.en),
    .len   (tmr_len),
    .done  (tmr_done)
  );

  // channel sets fetched by each trigger source
  always_comb begin
    foc_set = `FOC_BUS_V_CH; // see RULE_11
    case (FOC_SHUNT_MODE)
      sar_seq_pkg::SHUNT_SINGLE: foc_set = foc_set | `FOC_SINGLE_CH;
      sar_seq_pkg::SHUNT_DUAL:   foc_set = foc_set | `FOC_DUAL_CH;
      sar_seq_pkg::SHUNT_TRIPLE: foc_set = foc_set | `FOC_TRIPLE_CH;
      default:                   foc_set = foc_set;
    endcase
    t1_set = `T1_BUS_I_CH; // see RULE_12
    if (TIMER_POSITION_SOURCE_SELECT) begin // see RULE_13
      t1_set = t1_set | (PHASE_CHANNEL_SELECT ? `T1_PHASE1_CH
                                              : `T1_PHASE0_CH); // see RULE_14
    end
  end

  assign acc_sum = {1'b0, s.acc} + `ADC_CLK_MHZ;
  assign wmerged = be_merge(32'h0, WRITEDATA, BYTEENABLE);

  always_comb begin
    next_s = s;
    tmr_start = 1'b0;
    tmr_len = sample_len(s.ch, s.sper_lo, s.sper_hi);
    next_s.core_start = 1'b0;
    next_s.foc_v = 1'b0;
    next_s.t1_v = 1'b0;
    // fractional divider: 12 ticks in every 250 clocks
    if (acc_sum >= `SYS_CLK_MHZ) begin // see RULE_07
      next_s.acc = 8'(acc_sum - `SYS_CLK_MHZ);
      next_s.tick = 1'b1;
    end else begin
      next_s.acc = acc_sum[7:0];
      next_s.tick = 1'b0;
    end

    // sequencer
    case (s.st)
      sar_seq_pkg::ST_IDLE: begin
        if (s.en) begin
          if (s.foc_pend != 14'h0) begin // see RULE_06
            next_s.kind = sar_seq_pkg::K_FOC;
            next_s.ch = lowest_ch(s.foc_pend);
            next_s.st = sar_seq_pkg::ST_SAMPLE;
          end else if (s.t1_pend != 14'h0) begin
            next_s.kind = sar_seq_pkg::K_T1;
            next_s.ch = lowest_ch(s.t1_pend);
            next_s.st = sar_seq_pkg::ST_SAMPLE;
          end else if (s.busy && s.scan_rem != 14'h0) begin
            next_s.kind = sar_seq_pkg::K_SCAN;
            next_s.ch = lowest_ch(s.scan_rem); // see RULE_02
            next_s.st = sar_seq_pkg::ST_SAMPLE;
          end
          tmr_len = sample_len(next_s.ch, s.sper_lo, s.sper_hi);
          tmr_start = (next_s.st == sar_seq_pkg::ST_SAMPLE);
        end
      end
      sar_seq_pkg::ST_SAMPLE: begin
        if (tmr_done) begin
          next_s.st = sar_seq_pkg::ST_CONV;
          next_s.core_start = 1'b1;
        end
      end
      sar_seq_pkg::ST_CONV: begin
        if (CORE_DONE) begin
          next_s.st = sar_seq_pkg::ST_IDLE;
          case (s.kind)
            sar_seq_pkg::K_SCAN: begin
              next_s.res[s.ch] = align_word(CORE_DATA, s.align); // see RULE_03
              next_s.scan_rem = s.scan_rem & ~ch_bit(s.ch);
              if (next_s.scan_rem == 14'h0) begin // see RULE_22
                next_s.busy = 1'b0;
              end
            end
            sar_seq_pkg::K_FOC: begin
              next_s.trig_res = align_word(CORE_DATA, 1'b1); // see RULE_04
              next_s.trig_ch = s.ch;
              next_s.foc_v = 1'b1;
              next_s.foc_pend = s.foc_pend & ~ch_bit(s.ch);
            end
            default: begin
              next_s.trig_res = align_word(CORE_DATA, 1'b1); // see RULE_04
              next_s.trig_ch = s.ch;
              next_s.t1_v = 1'b1;
              next_s.t1_pend = s.t1_pend & ~ch_bit(s.ch);
            end
          endcase
        end
      end
      default: begin
        next_s.st = sar_seq_pkg::ST_IDLE;
      end
    endcase

    // a disabled converter drops all work
    if (!s.en) begin // see RULE_23
      next_s.st = sar_seq_pkg::ST_IDLE;
      next_s.busy = 1'b0;
      next_s.scan_rem = 14'h0;
      next_s.foc_pend = 14'h0;
      next_s.t1_pend = 14'h0;
    end

    // register bus: one wait cycle, then the answer
    next_s.ack = (READ || WRITE) && !s.ack;
    if (READ && !s.ack) begin
      if ({ADDRESS[7:2], 2'b00} == `SEQ_CTRL_OFS) begin
        next_s.rdata = {24'h0, s.en, s.busy, 3'b000, s.align, 1'b0,
                        s.done}; // see RULE_10
      end else if ({ADDRESS[7:2], 2'b00} == `SEQ_MASK_OFS) begin
        next_s.rdata = {18'h0, s.mask};
      end else if ({ADDRESS[7:2], 2'b00} == `SEQ_SPER_OFS) begin
        next_s.rdata = {20'h0, s.sper_hi, s.sper_lo};
      end else if (ADDRESS >= `SEQ_RES_BASE && ADDRESS <= `SEQ_RES_LAST) begin
        next_s.rdata = {16'h0, s.res[4'((ADDRESS - `SEQ_RES_BASE) >> 2)]};
      end else begin
        next_s.rdata = 32'h0;
      end
    end
    if (WRITE && !s.ack) begin
      if ({ADDRESS[7:2], 2'b00} == `SEQ_CTRL_OFS && BYTEENABLE[0]) begin
        next_s.en = WRITEDATA[`CTRL_EN_BIT];
        next_s.align = WRITEDATA[`CTRL_ALIGN_BIT];
        if (!WRITEDATA[`CTRL_DONE_BIT]) begin // see RULE_20
          next_s.done = 1'b0;
        end
        // start needs enable, a non-empty mask and an idle scan
        if (WRITEDATA[`CTRL_BUSY_BIT] && WRITEDATA[`CTRL_EN_BIT] &&
            s.mask != 14'h0 && !s.busy) begin // see RULE_05 RULE_19
          next_s.busy = 1'b1;
          next_s.scan_rem = s.mask;
        end
      end else if ({ADDRESS[7:2], 2'b00} == `SEQ_MASK_OFS) begin
        next_s.mask = 14'(be_merge({18'h0, s.mask}, wmerged, BYTEENABLE));
      end else if ({ADDRESS[7:2], 2'b00} == `SEQ_SPER_OFS) begin
        if (BYTEENABLE[0]) begin
          next_s.sper_lo = WRITEDATA[7:0];
        end
        if (BYTEENABLE[1]) begin
          next_s.sper_hi = WRITEDATA[11:8];
        end
      end
    end

    // hardware events win over software clears
    if (s.st == sar_seq_pkg::ST_CONV && CORE_DONE && s.en &&
        s.kind == sar_seq_pkg::K_SCAN &&
        (s.scan_rem & ~ch_bit(s.ch)) == 14'h0) begin // see RULE_20
      next_s.done = 1'b1;
    end
    if (s.en && FOC_ENABLE && FOC_TRIGGER) begin // see RULE_05
      next_s.foc_pend = next_s.foc_pend | foc_set;
    end
    if (s.en && T1_ENABLE && T1_TRIGGER) begin
      next_s.t1_pend = next_s.t1_pend | t1_set;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s <= '0;
      s.st <= sar_seq_pkg::ST_IDLE;
      s.kind <= sar_seq_pkg::K_SCAN;
      s.sper_lo <= `SPER_LO_RST;
      s.sper_hi <= `SPER_HI_RST;
    end else begin
      s <= next_s;
    end
  end

  assign WAITREQUEST = (READ || WRITE) && !s.ack;
  assign READDATA = s.rdata;
  assign FOC_RESULT_VALID = s.foc_v;
  assign T1_RESULT_VALID = s.t1_v;
  assign TRIG_CHANNEL = s.trig_ch;
  assign TRIG_RESULT = s.trig_res;
  assign CORE_CHANNEL = s.ch; // see RULE_01
  assign CORE_SAMPLE = (s.st == sar_seq_pkg::ST_SAMPLE);
  assign CORE_START = s.core_start;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  logic scan_store;
  logic trig_store;
  assign scan_store = s.st == sar_seq_pkg::ST_CONV && CORE_DONE && s.en &&
                      s.kind == sar_seq_pkg::K_SCAN;
  assign trig_store = s.st == sar_seq_pkg::ST_CONV && CORE_DONE && s.en &&
                      s.kind != sar_seq_pkg::K_SCAN;

  property p_start_needs_mask;
    $rose(s.busy) |-> $past(s.mask) != 14'h0;
  endproperty
  a_start_needs_mask: assert property (p_start_needs_mask) // see RULE_19
    else $error("scan started with an empty mask");

  property p_disable_drops_busy;
    // a write that enables and starts at once is allowed to raise busy
    !s.en ##1 !s.en |-> !s.busy && s.scan_rem == 14'h0;
  endproperty
  a_disable_drops_busy: assert property (p_disable_drops_busy) // see RULE_23
    else $error("busy survived a disabled converter");

  property p_trig_keeps_results;
    trig_store |=> $stable(s.res);
  endproperty
  a_trig_keeps_results: assert property (p_trig_keeps_results) // see RULE_03
    else $error("triggered result wrote a channel register");

  property p_trig_left_aligned;
    trig_store |=> (s.foc_v || s.t1_v) &&
                   s.trig_res == {1'b0, $past(CORE_DATA), 3'b000};
  endproperty
  a_trig_left_aligned: assert property (p_trig_left_aligned) // see RULE_04
    else $error("triggered result not left-second-high aligned");

  property p_trig_first;
    s.st == sar_seq_pkg::ST_IDLE && s.en && s.foc_pend != 14'h0 |=>
      s.st == sar_seq_pkg::ST_SAMPLE && s.kind == sar_seq_pkg::K_FOC;
  endproperty
  a_trig_first: assert property (p_trig_first) // see RULE_06
    else $error("scan served before a pending trigger");

  property p_scan_order;
    scan_store |-> s.ch == lowest_ch(s.scan_rem);
  endproperty
  a_scan_order: assert property (p_scan_order) // see RULE_02
    else $error("scan channel out of ascending order");

  property p_result_fill;
    scan_store |=> s.res[$past(s.ch)] ==
                   align_word($past(CORE_DATA), $past(s.align));
  endproperty
  a_result_fill: assert property (p_result_fill) // see RULE_16
    else $error("stored result has a wrong layout");

  property p_scan_end;
    scan_store && (s.scan_rem & ~ch_bit(s.ch)) == 14'h0 |=> !s.busy && s.done;
  endproperty
  a_scan_end: assert property (p_scan_end) // see RULE_22
    else $error("scan end did not drop busy and set done");

  property p_busy_holds;
    s.busy && trig_store |=> s.busy;
  endproperty
  a_busy_holds: assert property (p_busy_holds) // see RULE_22
    else $error("busy dropped by a triggered conversion");

  property p_channel_range;
    CORE_SAMPLE |-> CORE_CHANNEL < 4'd14;
  endproperty
  a_channel_range: assert property (p_channel_range) // see RULE_01
    else $error("converter channel out of range");

  c_scan_done: cover property ($fell(s.busy) && s.done);
  c_foc_result: cover property (s.foc_v);
  c_t1_result: cover property (s.t1_v);
  c_trig_in_scan: cover property (s.busy && trig_store);
endmodule
`default_nettype wire

// file: rtl/sar_seq_regs.svh
// register offsets, field positions, reset values and rates of the scan sequencer
// Notes on behaviour
// RULE_01 - drive a 12-bit converter core with fourteen channels, numbered 0 to 13
// RULE_02 - a scan converts only the enabled channels, lowest number first
// RULE_03 - scan results go to channel registers, triggered results go to engine or timer
// RULE_04 - triggered results are always delivered left-second-high aligned
// RULE_05 - triggers are started by hardware, scans only by a software write
// RULE_06 - a pending trigger converts first, then the scan resumes by itself
// RULE_07 - converter timing runs from a 12 MHz tick; sampling counts those ticks
// RULE_08 - software programs sample periods first; the setting is at least 3
// RULE_09 - software sets mask, periods, enable, then writes one to start
// RULE_10 - start/busy reads one during a scan, zero after; read results then
// RULE_11 - engine triggers use channel 2, plus 4, 0/1 or 0/1/4 by shunt mode
// RULE_12 - timer triggers convert channel 4 for bus current
// RULE_13 - a timer field selects the converter as position source for phase voltages
// RULE_14 - phase select 0 picks channels 10,9,8; 1 picks 10,12,13
// RULE_15 - each result word holds a high byte and a low byte; alignment selectable
// RULE_16 - result bits outside the 12-bit value always read zero
// RULE_17 - full scale reads 0x0fff or 0x7ff8, half 0x0800 or 0x4000
// RULE_18 - right alignment uses bits 11..0, left-second-high uses bits 14..3
// RULE_19 - start is ignored with an empty mask; writing zero never starts
// RULE_20 - done flag set by hardware at scan end, cleared by writing zero
// RULE_21 - period field: top bit clear gives count, set gives count times 8 plus 7
// RULE_22 - busy holds across inserted triggers, clears after the last result is stored
// RULE_23 - clearing enable aborts the scan, drops busy and ignores start writes
`ifndef SAR_SEQ_REGS_SVH
`define SAR_SEQ_REGS_SVH

`define SEQ_CTRL_OFS      8'h00
`define SEQ_MASK_OFS      8'h04
`define SEQ_SPER_OFS      8'h08
`define SEQ_RES_BASE      8'h40
`define SEQ_RES_LAST      8'h74

`define CTRL_EN_BIT       7
`define CTRL_BUSY_BIT     6
`define CTRL_ALIGN_BIT    2
`define CTRL_DONE_BIT     0

`define SPER_LO_RST       8'h33
`define SPER_HI_RST       4'h3
`define NUM_CH            14

`define FOC_BUS_V_CH      14'h0004
`define FOC_SINGLE_CH     14'h0010
`define FOC_DUAL_CH       14'h0003
`define FOC_TRIPLE_CH     14'h0013
`define T1_BUS_I_CH       14'h0010
`define T1_PHASE0_CH      14'h0700
`define T1_PHASE1_CH      14'h3400

`define SYS_CLK_MHZ       9'd250
`define ADC_CLK_MHZ       9'd12

`endif

// file: rtl/sar_seq_pkg.sv
// types shared by the scan sequencer files
package sar_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b100
  } seq_state_t;

  typedef enum logic [1:0] {
    K_SCAN = 2'b00,
    K_FOC  = 2'b01,
    K_T1   = 2'b10
  } conv_kind_t;

  typedef enum logic [1:0] {
    SHUNT_SINGLE = 2'b00,
    SHUNT_DUAL   = 2'b01,
    SHUNT_TRIPLE = 2'b10
  } shunt_mode_t;
endpackage

// file: rtl/sample_timer.sv
// sampling window counter on the converter tick
`timescale 1ns/1ns
`default_nettype none
module sample_timer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [5:0] len,
  // result
  output logic            done
);
  typedef struct packed {
    logic       run;
    logic [5:0] cnt;
  } tmr_t;

  tmr_t s;
  tmr_t next_s;

  // the window ends on the tick that counts its last cycle
  assign done = s.run & tick & (s.cnt <= 6'd1); // see RULE_07

  always_comb begin
    next_s = s;
    if (abort) begin
      next_s.run = 1'b0;
    end else if (start) begin
      next_s.run = 1'b1;
      next_s.cnt = (len == 6'd0) ? 6'd1 : len;
    end else if (done) begin
      next_s.run = 1'b0;
    end else if (s.run && tick) begin
      next_s.cnt = s.cnt - 6'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// file: dv/conv_core_model.sv
// behavioural converter core answering conversion starts
`timescale 1ns/1ns
`default_nettype none
module conv_core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // conversion request
  input  wire logic        start,
  input  wire logic [3:0]  ch,
  // test control
  input  wire logic [11:0] bias,
  input  wire logic        slow,
  // conversion answer
  output logic             done,
  output logic      [11:0] data
);
  int         cnt;
  logic [3:0] cur;
  // data lines toggle outside the done pulse so stale values never match
  always @(posedge clk) begin
    done <= 1'b0;
    data <= ~data;
    if (!rst_n) begin
      cnt  <= 0;
      data <= 12'h000;
    end else if (start) begin
      cnt <= slow ? 12 : 2;
      cur <= ch;
    end else if (cnt == 1) begin
      cnt  <= 0;
      done <= 1'b1;
      data <= bias ^ {3{cur}};
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// file: dv/tb_sar_adc_sampling_sequencer.sv
// self-checking bench for the scan and trigger sequencer
`timescale 1ns/1ns
`default_nettype none
`include "sar_seq_regs.svh"
module tb_sar_adc_sampling_sequencer;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        foc_en = 1'b0;
  logic [1:0]  shunt = 2'b00;
  logic        foc_trig = 1'b0;
  logic        t1_en = 1'b0;
  logic        t1_trig = 1'b0;
  logic        pos_src = 1'b0;
  logic        ph_sel = 1'b0;
  logic        foc_valid, t1_valid, core_sample, core_start, core_done;
  logic [3:0]  trig_ch, core_ch;
  logic [15:0] trig_res;
  logic [11:0] core_data;
  logic [11:0] bias = 12'hfff;
  logic        slow = 1'b0;
  logic [31:0] q, ctl;
  logic [3:0]  seq[$];
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          foc_n = 0;
  int          t1_n = 0;
  int          samp = 0;
  int          samp_len = 0;
  int          base, e, k;

  always #2 clk = ~clk;

  sar_adc_sampling_sequencer sar_adc_sampling_sequencer_inst (
    .CLK(clk), .RST_N(rst_n), .ADDRESS(address), .READ(read),
    .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(4'hf),
    .READDATA(readdata), .WAITREQUEST(waitrequest),
    .FOC_ENABLE(foc_en), .FOC_SHUNT_MODE(shunt), .FOC_TRIGGER(foc_trig),
    .FOC_RESULT_VALID(foc_valid), .T1_ENABLE(t1_en), .T1_TRIGGER(t1_trig),
    .TIMER_POSITION_SOURCE_SELECT(pos_src), .PHASE_CHANNEL_SELECT(ph_sel),
    .T1_RESULT_VALID(t1_valid), .TRIG_CHANNEL(trig_ch),
    .TRIG_RESULT(trig_res), .CORE_CHANNEL(core_ch),
    .CORE_SAMPLE(core_sample), .CORE_START(core_start),
    .CORE_DONE(core_done), .CORE_DATA(core_data));

  conv_core_model conv_core_model_inst (
    .clk(clk), .rst_n(rst_n), .start(core_start), .ch(core_ch),
    .bias(bias), .slow(slow), .done(core_done), .data(core_data));

  function automatic logic [11:0] ev(input logic [3:0] c);
    return bias ^ {3{c}};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one Avalon transfer, held until waitrequest is sampled low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 16);
    if (n >= 16) check(32'h1, 32'h0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    check(q, x);
  endtask

  task automatic wait_idle;
    int n = 0;
    do begin
      bus(1'b0, `SEQ_CTRL_OFS, 32'h0);
      n++;
    end while (q[`CTRL_BUSY_BIT] !== 1'b0 && n < 600);
    if (n >= 600) check(q, 32'h0);
  endtask

  task automatic chk_list(input logic [63:0] l, input int n);
    check(32'(seq.size()), 32'(n));
    for (int i = 0; i < n; i++) check(32'(seq[i]), 32'(l[4*i+:4]));
  endtask

  task automatic chk_mask(input logic [13:0] m);
    logic [63:0] l = 64'h0;
    int n = 0;
    for (int c = 0; c < 14; c++) if (m[c]) begin
      l[4*n+:4] = 4'(c);
      n++;
    end
    chk_list(l, n);
  endtask

  task automatic wait_cnt(input logic t1, input int n);
    int w = 0;
    while ((t1 ? t1_n : foc_n) < n && w < 3000) begin
      @(posedge clk);
      w++;
    end
    check(32'(t1 ? t1_n : foc_n), 32'(n));
  endtask

  task automatic pulse(input logic t1);
    @(posedge clk);
    if (t1) t1_trig <= 1'b1;
    else foc_trig <= 1'b1;
    @(posedge clk);
    t1_trig <= 1'b0;
    foc_trig <= 1'b0;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      complete_run();
    end
  end

  // records core order, sampling windows and triggered deliveries
  always @(posedge clk) begin
    if (core_start === 1'b1) seq.push_back(core_ch);
    if (core_sample === 1'b1) samp++;
    else if (samp != 0) begin
      samp_len = samp;
      samp = 0;
    end
    if (foc_valid === 1'b1 || t1_valid === 1'b1) begin
      foc_n += int'(foc_valid === 1'b1);
      t1_n += int'(t1_valid === 1'b1);
      check({16'h0, trig_res}, {17'h0, ev(trig_ch), 3'h0});
    end
  end

  initial begin
    logic [11:0] bl[5] = '{12'hfff, 12'hfff, 12'h800, 12'h800, 12'h000};
    logic [4:0]  al = 5'b11010;
    logic [13:0] fm[4] = '{`FOC_BUS_V_CH | `FOC_SINGLE_CH,
      `FOC_BUS_V_CH | `FOC_DUAL_CH, `FOC_BUS_V_CH | `FOC_TRIPLE_CH,
      `FOC_BUS_V_CH};
    logic [13:0] tm[3] = '{`T1_BUS_I_CH, `T1_BUS_I_CH | `T1_PHASE0_CH,
      `T1_BUS_I_CH | `T1_PHASE1_CH};
    int pt[3] = '{3, 15, 31};
    logic [13:0] pm[3] = '{14'h0001, 14'h0020, 14'h0100};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(`SEQ_CTRL_OFS, 32'h0);
    rd(`SEQ_MASK_OFS, 32'h0);
    rd(`SEQ_SPER_OFS, {20'h0, `SPER_HI_RST, `SPER_LO_RST});
    rd(`SEQ_RES_BASE, 32'h0);
    rd(8'h80, 32'h0);
    wr(`SEQ_CTRL_OFS, 32'hc0);
    rd(`SEQ_CTRL_OFS, 32'h80);
    wr(`SEQ_MASK_OFS, 32'h2007);
    wr(`SEQ_CTRL_OFS, 32'h80);
    rd(`SEQ_CTRL_OFS, 32'h80);
    for (int i = 0; i < 5; i++) begin
      bias = bl[i];
      ctl = {24'h0, 2'b10, 3'b0, al[i], 2'b0};
      seq.delete();
      wr(`SEQ_CTRL_OFS, ctl | 32'h40);
      bus(1'b0, `SEQ_CTRL_OFS, 32'h0);
      check(32'(q[`CTRL_BUSY_BIT]), 32'h1);
      wait_idle();
      chk_mask(14'h2007);
      check(q, ctl | 32'h1);
      for (int c = 0; c < 14; c++)
        rd(`SEQ_RES_BASE + 8'(4*c), !((14'h2007 >> c) & 1) ? 32'h0 :
           al[i] ? {17'h0, ev(4'(c)), 3'h0} : {20'h0, ev(4'(c))});
      wr(`SEQ_CTRL_OFS, ctl | 32'h1);
      rd(`SEQ_CTRL_OFS, ctl | 32'h1);
      wr(`SEQ_CTRL_OFS, ctl);
      rd(`SEQ_CTRL_OFS, ctl);
    end
    bias = 12'h5a5;
    foc_en <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      shunt <= 2'(m);
      seq.delete();
      base = foc_n;
      pulse(1'b0);
      wait_cnt(1'b0, base + $countones(fm[m]));
      chk_mask(fm[m]);
    end
    rd(`SEQ_RES_BASE, 32'h0);
    foc_en <= 1'b0;
    t1_en <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      pos_src <= (m != 0);
      ph_sel <= (m == 2);
      seq.delete();
      base = t1_n;
      pulse(1'b1);
      wait_cnt(1'b1, base + $countones(tm[m]));
      chk_mask(tm[m]);
    end
    foc_en <= 1'b1;
    shunt <= 2'b01;
    slow <= 1'b1;
    wr(`SEQ_MASK_OFS, 32'h3000);
    seq.delete();
    base = foc_n;
    wr(`SEQ_CTRL_OFS, 32'hc0);
    k = 0;
    while (seq.size() == 0 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    pulse(1'b0);
    bus(1'b0, `SEQ_CTRL_OFS, 32'h0);
    check(32'(q[`CTRL_BUSY_BIT]), 32'h1);
    wait_idle();
    chk_list(64'hd210c, 5);
    check(32'(foc_n), 32'(base + 3));
    rd(`SEQ_RES_BASE, 32'h0);
    rd(`SEQ_RES_BASE + 8'h30, {20'h0, ev(4'd12)});
    slow <= 1'b0;
    wr(`SEQ_CTRL_OFS, 32'h80);
    wr(`SEQ_MASK_OFS, 32'h3fff);
    wr(`SEQ_CTRL_OFS, 32'hc0);
    wr(`SEQ_CTRL_OFS, 32'h00);
    bus(1'b0, `SEQ_CTRL_OFS, 32'h0);
    check(q & 32'hc0, 32'h0);
    wr(`SEQ_CTRL_OFS, 32'h40);
    bus(1'b0, `SEQ_CTRL_OFS, 32'h0);
    check(q & 32'hc0, 32'h0);
    base = t1_n;
    pulse(1'b1);
    repeat (400) @(posedge clk);
    check(32'(t1_n), 32'(base));
    wr(`SEQ_SPER_OFS, 32'hb93);
    for (int i = 0; i < 3; i++) begin
      wr(`SEQ_MASK_OFS, {18'h0, pm[i]});
      wr(`SEQ_CTRL_OFS, 32'hc0);
      wait_idle();
      e = pt[i] * 250 / 12;
      check(32'(samp_len + 25 >= e && samp_len <= e + 25), 32'h1);
    end
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(`SEQ_CTRL_OFS, 32'h0);
    rd(`SEQ_SPER_OFS, {20'h0, `SPER_HI_RST, `SPER_LO_RST});
    complete_run();
  end
endmodule
`default_nettype wire
